// File: design/maint_counter.sv
// The AHB-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ps
// Contract
// R1 - Pre-forecast is indication only, no pin
// R2 - Shared stoppage output when any channel reached
// R3 - Pre-forecast threshold is forecast minus offset
// R4 - Stoppage threshold is forecast plus offset
// R5 - Single-stage build: forecast only
// R6 - Count inputs up to 30 Hz
// R7 - Control inputs accepted after qualification time
// R8 - Totalizer forecast output is 20 ms pulse
// R9 - Timer channel uses input as gate
// R10 - Reset clears selected channel, holds it
// R11 - Reset during re-monitor restores saved value
// R12 - Reset lamp while reset asserted
// R13 - Re-monitor shows saved value, lights lamp
// R14 - Select advances channel used by reset/view
// R15 - Inhibit blocks counts, outputs off, lamp
// R16 - Forecast output latched until channel reset
// R17 - Stoppage latched until its channel reset
// R18 - RUN on only in normal operation
// R19 - Power loss: inputs ignored, outputs off
// R20 - Six decimal digits, max 999999
// R21 - Timer accumulates input on-time
// R22 - Forecast 999999 means totalizer, carry on wrap
// R23 - Count on qualified rising edge
// R24 - Tenth-hour time base for timers
module maint_counter #(
	parameter int COUNT_Q = mcnt_pkg::COUNT_Q_CYC,
	parameter int SEL_Q = mcnt_pkg::SEL_Q_CYC,
	parameter int INH_Q = mcnt_pkg::INH_Q_CYC,
	parameter int RCV_Q = mcnt_pkg::RCV_Q_CYC,
	parameter int REQ_Q = mcnt_pkg::REQ_Q_CYC,
	parameter int RST_Q = mcnt_pkg::RST_Q_CYC,
	parameter int CARRY_Q = mcnt_pkg::CARRY_CYC,
	parameter int MS_Q = mcnt_pkg::MS_CYC,
	parameter int TENTH_MS = mcnt_pkg::TENTH_HOUR_MS,
	parameter bit SINGLE_STAGE = 1'b0
) (
	input wire logic sys_clk_i,
	input wire logic srst_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic [mcnt_pkg::NCH-1:0] count_i,
	input wire logic reset_in_i,
	input wire logic remonitor_i,
	input wire logic select_i,
	input wire logic inhibit_i,
	input wire logic out_request_i,
	input wire logic power_ok_i,
	input wire logic fault_i,
	output logic [mcnt_pkg::NCH-1:0] forecast_o,
	output logic stoppage_o,
	output logic run_o,
	output logic reset_lamp_o,
	output logic recovery_view_lamp_o,
	output logic inhibit_active_lamp_o,
	output logic [mcnt_pkg::NCH-1:0] pre_forecast_lamp_o,
	output logic [mcnt_pkg::VW-1:0] view_value_o,
	output logic [3:0] view_channel_o
);
	import mcnt_pkg::*;

	// ========================================
	// Parameter checks
	localparam longint QMAX = 64'h1ffffff;
	if (COUNT_Q < 1 || SEL_Q < 1 || INH_Q < 1 || RCV_Q < 1 ||
		REQ_Q < 1 || RST_Q < 1 || COUNT_Q > QMAX || SEL_Q > QMAX ||
		INH_Q > QMAX || RCV_Q > QMAX || REQ_Q > QMAX || RST_Q > QMAX) begin : g_bad_q
		$error("qualification count out of range");
	end
	if (CARRY_Q < 2 || CARRY_Q > 64'h3fffff) begin : g_bad_c
		$error("carry pulse count out of range");
	end
	if (MS_Q < 1 || MS_Q > 64'h3ffff || TENTH_MS < 1 || TENTH_MS > 64'h7ffff) begin : g_bad_t
		$error("time base count out of range");
	end

	localparam logic [CW-1:0] CARRY_L = CW'(CARRY_Q);
	localparam logic [DW-1:0] MS_L = DW'(MS_Q - 1);
	localparam logic [MW-1:0] TENTH_L = MW'(TENTH_MS - 1);

	state_t r_r;
	state_t r_nxt;

	// ========================================
	// Helpers
	function automatic logic [QW-1:0] qual_lim(input int i);
		int t;
		t = COUNT_Q;
		case (i)
			I_RST: t = RST_Q;
			I_RCV: t = RCV_Q;
			I_SEL: t = SEL_Q;
			I_INH: t = INH_Q;
			I_REQ: t = REQ_Q;
			default: t = COUNT_Q;
		endcase
		return QW'(t - 1);
	endfunction

	// Returns {hit, channel} for a per-channel register bank
	function automatic logic [4:0] chan_dec(input logic [11:0] a, input logic [11:0] base);
		logic [11:0] d;
		d = a - base;
		if (a >= base && d < 12'(NCH * 4) && a[1:0] == 2'h0) begin
			return {1'b1, d[5:2]};
		end
		return 5'h00;
	endfunction

	function automatic logic [31:0] reg_read(input state_t s, input logic [11:0] a);
		logic [31:0] d;
		logic [4:0] c;
		d = 32'h0;
		if (a == A_MODE) begin
			d[NCH-1:0] = s.timer_sel;
		end
		if (a == A_STATUS) begin
			d[ST_SEL+:4] = s.sel;
			d[ST_RST] = s.rst_lamp;
			d[ST_RCV] = s.rcv_lamp;
			d[ST_INH] = s.inh_lamp;
			d[ST_RUN] = s.run_out;
			d[ST_STOP] = s.stop_out;
			d[ST_FC+:NCH] = s.fc_out;
			d[ST_PRE+:NCH] = s.pre_lamp;
		end
		if (a == A_VIEW) begin
			d[VW-1:0] = s.view;
		end
		c = chan_dec(a, A_FCAST);
		if (c[4]) begin
			d[VW-1:0] = s.fcast[c[3:0]];
		end
		c = chan_dec(a, A_PRE);
		if (c[4]) begin
			d[OW-1:0] = s.pre_ofs[c[3:0]];
		end
		c = chan_dec(a, A_STOP);
		if (c[4]) begin
			d[OW-1:0] = s.stop_ofs[c[3:0]];
		end
		c = chan_dec(a, A_VAL);
		if (c[4]) begin
			d[VW-1:0] = s.val[c[3:0]];
		end
		return d;
	endfunction

	// ========================================
	// Next state
	always_comb begin
		logic [NIN-1:0] raw;
		logic [NIN-1:0] q;
		logic [NIN-1:0] rise;
		logic alive;
		logic tick;
		logic inh;
		logic rst_on;
		logic rmon;
		logic hold;
		logic inc;
		logic sel_ch;
		logic used;
		logic tot;
		logic [VW-1:0] fcv;
		logic [VW-1:0] pofs;
		logic [VW:0] stop_thr;
		logic [VW-1:0] pre_thr;
		logic [4:0] c;
		logic [NCH-1:0] stop_vis;
		// Every local gets a value up front so no path infers a latch
		q = '0;
		rise = '0;
		alive = 1'b0;
		tick = 1'b0;
		inh = 1'b0;
		rst_on = 1'b0;
		rmon = 1'b0;
		hold = 1'b0;
		inc = 1'b0;
		sel_ch = 1'b0;
		used = 1'b0;
		tot = 1'b0;
		fcv = '0;
		pofs = '0;
		stop_thr = '0;
		pre_thr = '0;
		c = '0;
		stop_vis = '0;
		raw = {fault_i, power_ok_i, out_request_i, inhibit_i,
			select_i, remonitor_i, reset_in_i, count_i};
		r_nxt = r_r;
		// Three-stage synchroniser; a level counts once stages two and three agree
		r_nxt.s1 = raw;
		r_nxt.s2 = r_r.s1;
		r_nxt.s3 = r_r.s2;
		for (int i = 0; i < NIN; i++) begin
			if (r_r.s2[i] == r_r.s3[i]) begin
				r_nxt.filt[i] = r_r.s3[i];
			end
			// Accept only after the input stayed active for its full time
			// A dropout restarts the count, so a bouncing pin never adds up
			if (!r_r.filt[i]) begin
				r_nxt.qcnt[i] = '0; // R7
				r_nxt.qual[i] = 1'b0;
			end else if (r_r.qcnt[i] < qual_lim(i)) begin
				r_nxt.qcnt[i] = r_r.qcnt[i] + 1'b1; // R7
			end else begin
				r_nxt.qual[i] = 1'b1; // R7
			end
		end
		r_nxt.qprev = r_r.qual;
		// Power is taken straight from the filtered level, so loss acts fast
		alive = r_r.filt[I_PWR]; // R19
		q = r_r.qual & {NIN{alive}}; // R19
		rise = q & ~r_r.qprev;
		inh = q[I_INH];
		rst_on = q[I_RST];
		rmon = q[I_RCV];
		// Millisecond enable; timer channels keep their own sub-count
		tick = (r_r.ms_div == MS_L); // R24
		r_nxt.ms_div = tick ? '0 : r_r.ms_div + 1'b1; // R24
		if (rise[I_SEL]) begin
			r_nxt.sel = (r_r.sel == 4'(NCH - 1)) ? 4'h0 : r_r.sel + 4'h1; // R14
		end
		// Output number request jumps to the lowest channel with its forecast on
		if (rise[I_REQ]) begin
			for (int ch = NCH - 1; ch >= 0; ch--) begin
				if (r_r.fc_lat[ch]) begin
					r_nxt.sel = 4'(ch);
				end
			end
		end
		// Only channels 0..NCH-1 are ever selected, so indexing by sel stays in range
		for (int ch = 0; ch < NCH; ch++) begin
			sel_ch = (r_r.sel == 4'(ch));
			hold = inh | (rst_on & sel_ch) | !alive; // R10 R15
			inc = 1'b0;
			// Carry pulse runs down by itself; a reset is the only thing that cuts it
			if (r_r.carry[ch] != '0) begin
				r_nxt.carry[ch] = r_r.carry[ch] - 1'b1; // R8
			end
			if (!hold) begin
				// Timer sub-count survives a dropped gate so short runs still add up
				if (r_r.timer_sel[ch]) begin
					if (q[ch] && tick) begin // R9 R21
						if (r_r.ms_acc[ch] == TENTH_L) begin
							r_nxt.ms_acc[ch] = '0; // R24
							inc = 1'b1;
						end else begin
							r_nxt.ms_acc[ch] = r_r.ms_acc[ch] + 1'b1; // R21
						end
					end
				end else begin
					inc = rise[ch]; // R23 R6
				end
			end
			fcv = r_r.fcast[ch];
			used = (fcv != '0);
			tot = (fcv == VAL_MAX); // R22
			if (inc) begin
				if (r_r.val[ch] == VAL_MAX) begin
					r_nxt.val[ch] = '0; // R20
					if (tot) begin
						r_nxt.carry[ch] = CARRY_L; // R22 R8
					end
				end else begin
					r_nxt.val[ch] = r_r.val[ch] + 1'b1; // R20
				end
			end
			pofs = VW'(r_r.pre_ofs[ch]);
			pre_thr = (fcv > pofs) ? fcv - pofs : '0; // R3
			stop_thr = {1'b0, fcv} + (VW + 1)'(r_r.stop_ofs[ch]); // R4
			if (used && !tot && r_r.val[ch] >= fcv) begin
				r_nxt.fc_lat[ch] = 1'b1; // R16
			end
			if (!SINGLE_STAGE && used && !tot && {1'b0, r_r.val[ch]} >= stop_thr) begin
				r_nxt.stop_lat[ch] = 1'b1; // R17 R5
			end
			r_nxt.pre_lat[ch] = !SINGLE_STAGE && used && !tot &&
				r_r.val[ch] >= pre_thr; // R1 R5
			// Channel reset wins over any count in the same cycle
			if (rise[I_RST] && sel_ch) begin
				if (rmon) begin
					r_nxt.val[ch] = r_r.saved[ch]; // R11
				end else begin
					r_nxt.saved[ch] = r_r.val[ch];
					r_nxt.val[ch] = '0; // R10
					r_nxt.ms_acc[ch] = '0;
				end
				r_nxt.fc_lat[ch] = 1'b0; // R16
				r_nxt.stop_lat[ch] = 1'b0; // R17
				r_nxt.pre_lat[ch] = 1'b0;
				r_nxt.carry[ch] = '0;
			end
			r_nxt.fc_out[ch] = (tot ? (r_r.carry[ch] != '0) : r_r.fc_lat[ch]) &&
				!hold; // R8 R10 R15 R19
			stop_vis[ch] = r_r.stop_lat[ch] & ~(rst_on & sel_ch); // R10
		end
		r_nxt.stop_out = !SINGLE_STAGE && (|stop_vis) && alive && !inh; // R2 R15 R19
		r_nxt.run_out = alive && !inh && !q[I_FLT]; // R18
		r_nxt.rst_lamp = rst_on; // R12
		r_nxt.rcv_lamp = rmon; // R13
		r_nxt.inh_lamp = inh; // R15
		r_nxt.pre_lamp = r_r.pre_lat & {NCH{alive}}; // R1
		r_nxt.view = rmon ? r_r.saved[r_r.sel] : r_r.val[r_r.sel]; // R13 R14
		// ========================================
		// AHB-Lite slave, zero wait states
		r_nxt.wr_pend = 1'b0;
		if (hsel_i && hready_i && htrans_i[1]) begin
			// Writes above the map are dropped, as reads there return zero
			r_nxt.wr_pend = hwrite_i && (haddr_i[31:12] == '0);
			r_nxt.wr_addr = haddr_i[11:0];
			if (!hwrite_i) begin
				// Address bits above the map alias nothing; reads there return zero
				r_nxt.rdata = (haddr_i[31:12] == '0) ? reg_read(r_r, haddr_i[11:0]) : 32'h0;
			end
		end
		if (r_r.wr_pend) begin
			if (r_r.wr_addr == A_MODE) begin
				r_nxt.timer_sel = hwdata_i[NCH-1:0];
			end
			c = chan_dec(r_r.wr_addr, A_FCAST);
			if (c[4]) begin
				// Values beyond six digits are clamped to the top value
				r_nxt.fcast[c[3:0]] = (hwdata_i[VW-1:0] > VAL_MAX) ? VAL_MAX :
					hwdata_i[VW-1:0];
			end
			c = chan_dec(r_r.wr_addr, A_PRE);
			if (c[4]) begin
				r_nxt.pre_ofs[c[3:0]] = hwdata_i[OW-1:0];
			end
			c = chan_dec(r_r.wr_addr, A_STOP);
			if (c[4]) begin
				r_nxt.stop_ofs[c[3:0]] = hwdata_i[OW-1:0];
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			r_r <= '0;
		end else begin
			r_r <= r_nxt;
		end
	end

	// ========================================
	// Outputs
	assign hrdata_o = r_r.rdata;
	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;
	assign forecast_o = r_r.fc_out;
	assign stoppage_o = r_r.stop_out;
	assign run_o = r_r.run_out;
	assign reset_lamp_o = r_r.rst_lamp;
	assign recovery_view_lamp_o = r_r.rcv_lamp;
	assign inhibit_active_lamp_o = r_r.inh_lamp;
	assign pre_forecast_lamp_o = r_r.pre_lamp;
	assign view_value_o = r_r.view;
	assign view_channel_o = r_r.sel;

endmodule

// File: design/mcnt_pkg.sv
package mcnt_pkg;
	// ========================================
	// Sizes
	localparam int NCH = 9;
	localparam int NIN = 16;
	localparam int VW = 20;
	localparam int OW = 17;
	localparam int QW = 25;
	localparam int MW = 19;
	localparam int CW = 22;
	localparam int DW = 18;
	localparam logic [VW-1:0] VAL_MAX = 20'hf423f;
	// ========================================
	// Input slots in the synchroniser vector
	localparam int I_RST = 9;
	localparam int I_RCV = 10;
	localparam int I_SEL = 11;
	localparam int I_INH = 12;
	localparam int I_REQ = 13;
	localparam int I_PWR = 14;
	localparam int I_FLT = 15;
	// ========================================
	// Timing
	localparam int CLK_MHZ = 200;
	localparam int COUNT_Q_US = 10000;
	localparam int SEL_Q_US = 16700;
	localparam int INH_Q_US = 16700;
	localparam int RCV_Q_US = 30000;
	localparam int REQ_Q_US = 30000;
	localparam int RST_Q_US = 100000;
	localparam int CARRY_US = 20000;
	localparam int MS_US = 1000;
	localparam int TENTH_HOUR_MS = 360000;
	localparam int COUNT_Q_CYC = COUNT_Q_US * CLK_MHZ;
	localparam int SEL_Q_CYC = SEL_Q_US * CLK_MHZ;
	localparam int INH_Q_CYC = INH_Q_US * CLK_MHZ;
	localparam int RCV_Q_CYC = RCV_Q_US * CLK_MHZ;
	localparam int REQ_Q_CYC = REQ_Q_US * CLK_MHZ;
	localparam int RST_Q_CYC = RST_Q_US * CLK_MHZ;
	localparam int CARRY_CYC = CARRY_US * CLK_MHZ;
	localparam int MS_CYC = MS_US * CLK_MHZ;
	// ========================================
	// Register map (byte addresses)
	localparam logic [11:0] A_MODE = 12'h000;
	localparam logic [11:0] A_STATUS = 12'h004;
	localparam logic [11:0] A_VIEW = 12'h008;
	localparam logic [11:0] A_FCAST = 12'h040;
	localparam logic [11:0] A_PRE = 12'h080;
	localparam logic [11:0] A_STOP = 12'h0c0;
	localparam logic [11:0] A_VAL = 12'h100;
	localparam int ST_SEL = 0;
	localparam int ST_RST = 4;
	localparam int ST_RCV = 5;
	localparam int ST_INH = 6;
	localparam int ST_RUN = 7;
	localparam int ST_STOP = 8;
	localparam int ST_FC = 9;
	localparam int ST_PRE = 18;
	// ========================================
	// Whole block state; everything resets to zero
	typedef struct packed {
		logic [NIN-1:0] s1;
		logic [NIN-1:0] s2;
		logic [NIN-1:0] s3;
		logic [NIN-1:0] filt;
		logic [NIN-1:0][QW-1:0] qcnt;
		logic [NIN-1:0] qual;
		logic [NIN-1:0] qprev;
		logic [NCH-1:0][VW-1:0] val;
		logic [NCH-1:0][VW-1:0] saved;
		logic [NCH-1:0][VW-1:0] fcast;
		logic [NCH-1:0][OW-1:0] pre_ofs;
		logic [NCH-1:0][OW-1:0] stop_ofs;
		logic [NCH-1:0][MW-1:0] ms_acc;
		logic [NCH-1:0][CW-1:0] carry;
		logic [NCH-1:0] fc_lat;
		logic [NCH-1:0] stop_lat;
		logic [NCH-1:0] pre_lat;
		logic [NCH-1:0] timer_sel;
		logic [3:0] sel;
		logic [DW-1:0] ms_div;
		logic [NCH-1:0] fc_out;
		logic stop_out;
		logic run_out;
		logic rst_lamp;
		logic rcv_lamp;
		logic inh_lamp;
		logic [NCH-1:0] pre_lamp;
		logic [VW-1:0] view;
		logic wr_pend;
		logic [11:0] wr_addr;
		logic [31:0] rdata;
	} state_t;
endpackage

// File: sim/maint_counter_chk.sv
`timescale 1ns/1ps
module maint_counter_chk
	import mcnt_pkg::*;
#(
	parameter int INH_Q = 10,
	parameter int RST_Q = 16
) (
	input wire logic sys_clk_i,
	input wire logic srst_i,
	input wire logic reset_in_i,
	input wire logic remonitor_i,
	input wire logic inhibit_i,
	input wire logic power_ok_i,
	input wire logic fault_i,
	input wire logic hreadyout_o,
	input wire logic hresp_o,
	input wire logic [mcnt_pkg::NCH-1:0] forecast_o,
	input wire logic stoppage_o,
	input wire logic run_o,
	input wire logic reset_lamp_o,
	input wire logic recovery_view_lamp_o,
	input wire logic inhibit_active_lamp_o,
	input wire logic [mcnt_pkg::VW-1:0] view_value_o,
	input wire logic [3:0] view_channel_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (srst_i);
	// ========================================
	// Pin high-time counters, saturating
	logic [7:0] rst_cnt, inh_cnt, ok_cnt, flt_cnt;
	function automatic logic [7:0] up(input logic [7:0] c, input logic on);
		return on ? c + {7'h0, c != 8'hff} : 8'h00;
	endfunction
	always_ff @(posedge sys_clk_i) begin
		rst_cnt <= up(rst_cnt, reset_in_i && !srst_i);
		inh_cnt <= up(inh_cnt, inhibit_i && !srst_i);
		ok_cnt <= up(ok_cnt, power_ok_i && !inhibit_i && !fault_i && !srst_i);
		flt_cnt <= up(flt_cnt, fault_i && !srst_i);
	end
	// ========================================
	// Properties
	sequence s_plain_rst;
		$rose(reset_lamp_o) && !recovery_view_lamp_o
			##1 (reset_lamp_o && !recovery_view_lamp_o) [*3];
	endsequence
	property p_okay;
		hreadyout_o && !hresp_o;
	endproperty
	property p_inh_off;
		inhibit_active_lamp_o && $past(inhibit_active_lamp_o)
			|-> !run_o && !stoppage_o && forecast_o == '0;
	endproperty
	property p_inh_lamp;
		int'(inh_cnt) == INH_Q + 14 |-> inhibit_active_lamp_o;
	endproperty
	property p_rst_early;
		int'(rst_cnt) == RST_Q |-> !reset_lamp_o;
	endproperty
	property p_rst_on;
		int'(rst_cnt) == RST_Q + 14 |-> reset_lamp_o;
	endproperty
	property p_rst_view;
		s_plain_rst |-> view_value_o == '0 && !forecast_o[view_channel_o];
	endproperty
	property p_rcv_off;
		(!remonitor_i) [*8] |-> !recovery_view_lamp_o;
	endproperty
	property p_stop_hold;
		$fell(stoppage_o) |-> ##[0:2] (reset_lamp_o || inhibit_active_lamp_o || !power_ok_i);
	endproperty
	property p_pwr_off;
		(!power_ok_i) [*8] |-> !run_o && !stoppage_o && forecast_o == '0;
	endproperty
	property p_run_on;
		ok_cnt == 8'h28 |-> run_o;
	endproperty
	property p_run_flt;
		flt_cnt == 8'h1e |-> !run_o;
	endproperty
	a_okay: assert property (p_okay) else $error("bus answer not zero-wait OKAY");
	a_inh_off: assert property (p_inh_off) else $error("output on under inhibit");
	a_inh_lamp: assert property (p_inh_lamp) else $error("inhibit lamp late");
	a_rst_early: assert property (p_rst_early) else $error("reset taken early");
	a_rst_on: assert property (p_rst_on) else $error("reset lamp missing");
	a_rst_view: assert property (p_rst_view) else $error("reset left value");
	a_rcv_off: assert property (p_rcv_off) else $error("recovery lamp stuck");
	a_stop_hold: assert property (p_stop_hold) else $error("stoppage dropped");
	a_pwr_off: assert property (p_pwr_off) else $error("output on without power");
	a_run_on: assert property (p_run_on) else $error("run missing");
	a_run_flt: assert property (p_run_flt) else $error("run on with fault");
endmodule
bind maint_counter maint_counter_chk #(.INH_Q(INH_Q), .RST_Q(RST_Q)) u_chk (.sys_clk_i,
	.srst_i, .reset_in_i, .remonitor_i, .inhibit_i, .power_ok_i, .fault_i, .hreadyout_o,
	.hresp_o, .forecast_o, .stoppage_o, .run_o, .reset_lamp_o, .recovery_view_lamp_o,
	.inhibit_active_lamp_o, .view_value_o, .view_channel_o);

// File: sim/mcnt_sensors.sv
`timescale 1ns/1ps
module mcnt_sensors (
	input wire logic sys_clk_i,
	input wire logic go_i,
	input wire logic [mcnt_pkg::NCH-1:0] mask_i,
	input wire logic [7:0] n_i,
	input wire logic [7:0] hi_i,
	output logic [mcnt_pkg::NCH-1:0] count_o,
	output logic busy_o
);
	import mcnt_pkg::*;
	// ========================================
	// Whole pulses only; a long high phase acts as a timer gate
	initial begin
		count_o = '0;
		busy_o = 1'b0;
		forever begin
			@(posedge sys_clk_i);
			if (go_i) begin
				busy_o <= 1'b1;
				repeat (n_i) begin
					count_o <= mask_i;
					repeat (hi_i) @(posedge sys_clk_i);
					count_o <= '0;
					repeat (20) @(posedge sys_clk_i);
				end
				busy_o <= 1'b0;
			end
		end
	end
endmodule

// File: sim/nine_channel_maintenance_counter_tb.sv
`timescale 1ns/1ps
module nine_channel_maintenance_counter_tb;
	import mcnt_pkg::*;
	logic clk, srst, hsel, hwrite, go, pwr, busy, hrdy, hresp, stop, run, rl, rvl, il, oreq;
	logic [1:0] htrans;
	logic [2:0] hsz;
	logic [31:0] haddr, hwdata, hrdata, rq;
	logic [4:0] ctl;
	logic [8:0] cnt, mask, fc, pl;
	logic [7:0] np, hi;
	logic [19:0] vv;
	logic [3:0] vc;
	int failures, n_tests, cyc;
	// Shortened timing so every scenario fits the cycle budget
	localparam int Q_COUNT = 8, Q_SEL = 10, Q_INH = 10, Q_RCV = 12, Q_REQ = 12;
	localparam int Q_RST = 16, Q_CARRY = 20, Q_MS = 4, Q_TENTH = 5;
	maint_counter #(.COUNT_Q(Q_COUNT), .SEL_Q(Q_SEL), .INH_Q(Q_INH), .RCV_Q(Q_RCV),
		.REQ_Q(Q_REQ), .RST_Q(Q_RST), .CARRY_Q(Q_CARRY), .MS_Q(Q_MS), .TENTH_MS(Q_TENTH))
		u_dut (.sys_clk_i(clk), .srst_i(srst),
		.hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsz),
		.hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy),
		.hresp_o(hresp), .count_i(cnt), .reset_in_i(ctl[0]), .remonitor_i(ctl[1]),
		.select_i(ctl[2]), .inhibit_i(ctl[3]), .out_request_i(oreq), .power_ok_i(pwr),
		.fault_i(ctl[4]), .forecast_o(fc), .stoppage_o(stop), .run_o(run), .reset_lamp_o(rl),
		.recovery_view_lamp_o(rvl), .inhibit_active_lamp_o(il), .pre_forecast_lamp_o(pl),
		.view_value_o(vv), .view_channel_o(vc));
	mcnt_sensors u_sens (.sys_clk_i(clk), .go_i(go), .mask_i(mask), .n_i(np), .hi_i(hi),
		.count_o(cnt), .busy_o(busy));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// ========================================
	// Shared tasks
	task print_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task bus(input int w, input logic [11:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {20'h0, a};
		htrans <= 2'h2;
		hwrite <= (w != 0);
		hsz <= 3'h2;
		do @(posedge clk); while (hrdy !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hrdy !== 1'b1);
		rq = hrdata;
	endtask
	// Pins held well past qualification so every press is taken once
	task hold(input logic [4:0] v, input int n);
		ctl <= v;
		repeat (n) @(posedge clk);
	endtask
	task pulse(input logic [8:0] m, input logic [7:0] n, input logic [7:0] h);
		mask <= m;
		np <= n;
		hi <= h;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		@(posedge clk);
		while (busy) @(posedge clk);
		repeat (8) @(posedge clk);
	endtask
	// ========================================
	// Scenarios
	task t_regs;
		bus(0, A_MODE, 0);
		chk(rq, 32'h0);
		bus(1, A_FCAST + 12'h4, 32'hfffff);
		bus(0, A_FCAST + 12'h4, 0);
		chk(rq, {12'h0, VAL_MAX});
		bus(1, A_VAL, 32'h5);
		bus(0, A_VAL, 0);
		chk(rq, 32'h0);
		bus(0, 12'h200, 0);
		chk(rq, 32'h0);
	endtask
	task t_count;
		bus(1, A_FCAST, 32'h5);
		bus(1, A_PRE, 32'h2);
		bus(1, A_STOP, 32'h2);
		pulse(9'h001, 2, 20);
		chk(pl[0], 1'b0);
		pulse(9'h001, 1, 20);
		chk(pl[0], 1'b1);
		chk(fc, 9'h000);
		pulse(9'h001, 2, 20);
		chk(fc, 9'h001);
		chk(stop, 1'b0);
		pulse(9'h001, 2, 20);
		chk(stop, 1'b1);
		bus(0, A_VAL, 0);
		chk(rq, 32'h7);
	endtask
	task t_reset;
		hold(5'h01, 30);
		chk(rl, 1'b1);
		chk(stop, 1'b0);
		hold(5'h00, 20);
		chk(vv, 20'h0);
		chk(fc[0], 1'b0);
	endtask
	task t_remon;
		hold(5'h02, 30);
		chk(rvl, 1'b1);
		chk(vv, 20'h7);
		hold(5'h03, 30);
		hold(5'h02, 10);
		hold(5'h00, 20);
		bus(0, A_VAL, 0);
		chk(rq, 32'h7);
	endtask
	task t_inhibit;
		bus(1, A_FCAST + 12'h8, 32'h1);
		hold(5'h08, 30);
		chk(il, 1'b1);
		chk(run, 1'b0);
		pulse(9'h004, 2, 20);
		bus(0, A_VAL + 12'h8, 0);
		chk(rq, 32'h0);
		hold(5'h00, 30);
		chk(run, 1'b1);
		pulse(9'h004, 1, 20);
		chk(fc[2], 1'b1);
	endtask
	task t_select;
		hold(5'h04, 30);
		hold(5'h00, 20);
		chk(vc, 4'h1);
		hold(5'h04, 30);
		hold(5'h00, 20);
		chk(vv, 20'h1);
		hold(5'h01, 30);
		hold(5'h00, 20);
		bus(0, A_VAL + 12'h8, 0);
		chk(rq, 32'h0);
		bus(0, A_VAL, 0);
		chk(rq, 32'h7);
	endtask
	// Gate of 200 cycles at 20 cycles per tenth hour gives about nine steps
	task t_timer;
		bus(1, A_MODE, 32'h8);
		bus(1, A_FCAST + 12'hc, 32'h64);
		pulse(9'h008, 1, 200);
		bus(0, A_VAL + 12'hc, 0);
		chk(rq >= 32'h8 && rq <= 32'ha, 1'b1);
	endtask
	task t_power;
		pwr <= 1'b0;
		pulse(9'h001, 1, 20);
		chk(run, 1'b0);
		chk(fc, 9'h000);
		pwr <= 1'b1;
		repeat (20) @(posedge clk);
		bus(0, A_VAL, 0);
		chk(rq, 32'h7);
	endtask
	task t_fault;
		hold(5'h10, 30);
		chk(run, 1'b0);
		hold(5'h00, 30);
		chk(run, 1'b1);
	endtask
	// Channel 0 is the only one with its forecast latched, while channel 2 is selected
	task t_request;
		oreq <= 1'b1;
		repeat (30) @(posedge clk);
		oreq <= 1'b0;
		repeat (20) @(posedge clk);
		chk(vc, 4'h0);
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures++;
			print_verdict();
		end
	end
	initial begin
		{srst, hsel, hwrite, go, htrans, haddr, hwdata, ctl, mask, np, hi, hsz, oreq} = '0;
		srst = 1'b1;
		pwr = 1'b1;
		failures = 0;
		n_tests = 0;
		cyc = 0;
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		t_regs();
		t_count();
		t_reset();
		t_remon();
		t_inhibit();
		t_select();
		t_timer();
		t_power();
		t_fault();
		t_request();
		print_verdict();
	end
endmodule
